// *** core/apsc_pkg.sv ***
// Shared constants, types and decode functions of the phase search control block
package apsc_pkg;
	localparam int ADDR_W = 10;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CMD = 8'h50;
	localparam logic [7:0] IDX_STATUS = 8'h51;
	localparam logic [7:0] IDX_VMASK = 8'h52;
	localparam logic [7:0] IDX_HAFT = 8'h53;
	localparam logic [7:0] IDX_HBEF = 8'h54;
	localparam logic [7:0] IDX_OPT = 8'h55;
	localparam logic [7:0] IDX_THR = 8'h56;
	localparam logic [7:0] IDX_RES3 = 8'h57;
	localparam logic [7:0] IDX_RES2 = 8'h58;
	localparam logic [7:0] IDX_RES1 = 8'h59;
	localparam logic [7:0] IDX_RES0 = 8'h5A;
	localparam logic [7:0] IDX_IRQ_STS = 8'h5C;
	localparam logic [7:0] IDX_IRQ_MSK = 8'h5D;
	// Reset values
	localparam logic [7:0] RST_VMASK = 8'h01;
	localparam logic [7:0] RST_HMASK = 8'h01;
	localparam logic [7:0] RST_OPT = 8'h20;
	localparam logic [7:0] RST_THR = 8'h0A;
	// Field positions
	localparam int VM_BEF_LSB = 0;
	localparam int VM_AFT_LSB = 4;
	localparam int OPT_BLUE = 0;
	localparam int OPT_GREEN = 1;
	localparam int OPT_RED = 2;
	localparam int OPT_WORST = 3;
	localparam int OPT_SLOW = 4;
	localparam int OPT_VSUPD = 5;
	localparam int OPT_SRST = 6;
	localparam int STS_BUSY = 7;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WIN = 1;
	localparam int IRQ_W = 2;
	// Commands and step lengths
	localparam logic [2:0] CMD_PHASE = 3'b011;
	localparam logic [2:0] CMD_WINDOW = 3'b100;
	localparam logic [6:0] STEP_FAST = 7'd28;
	localparam logic [6:0] STEP_SLOW = 7'd64;
	localparam int THR_SHIFT = 2;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} apsc_pix_s;

	typedef struct packed {
		logic valid;
		logic hs;
		logic vs;
		apsc_pix_s pix;
	} apsc_video_s;

	typedef struct packed {
		logic [2:0] bef_code;
		logic [2:0] aft_code;
		logic [7:0] h_aft;
		logic [7:0] h_bef;
		logic [2:0] ch_off;
		logic [7:0] thr;
	} apsc_mcfg_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARM = 3'b001,
		ST_STEP = 3'b010,
		ST_FINAL = 3'b011,
		ST_WIN = 3'b100
	} apsc_state_e;

	function automatic logic [5:0] lines_before(input logic [2:0] code);
		case (code)
			3'h0: lines_before = 6'd0;
			3'h1: lines_before = 6'd1;
			3'h2: lines_before = 6'd2;
			3'h3: lines_before = 6'd4;
			3'h4: lines_before = 6'd6;
			3'h5: lines_before = 6'd8;
			3'h6: lines_before = 6'd10;
			default: lines_before = 6'd12;
		endcase
	endfunction

	function automatic logic [5:0] lines_after(input logic [2:0] code);
		case (code)
			3'h0: lines_after = 6'd5;
			3'h1: lines_after = 6'd18;
			3'h2: lines_after = 6'd19;
			3'h3: lines_after = 6'd20;
			3'h4: lines_after = 6'd22;
			3'h5: lines_after = 6'd25;
			3'h6: lines_after = 6'd41;
			default: lines_after = 6'd44;
		endcase
	endfunction
endpackage

// *** core/apsc_measure.sv ***
// Masked transition counter that scores the current sampling phase
`timescale 1ns/1ps
`default_nettype none
module apsc_measure #(
	parameter int ACC_W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration and video
	input wire apsc_pkg::apsc_mcfg_s cfg,
	input wire apsc_pkg::apsc_video_s video,
	// Score
	input wire logic clear,
	output logic [ACC_W-1:0] acc
);
	logic [11:0] pix_cnt_r, line_len_r, line_cnt_r, frame_len_r;
	logic [ACC_W-1:0] acc_r;
	apsc_pkg::apsc_pix_s prev_r;
	logic prev_ok_r;
	logic [12:0] l_aft, l_bef, p_aft, p_bef;
	logic line_ok, pix_ok, win;
	logic [9:0] level;
	logic [2:0] hit;
	logic [1:0] nhit;

	function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	if (ACC_W < 8 || ACC_W > 32)
		$error("apsc_measure: ACC_W must be 8..32");

	assign l_aft = {7'h00, apsc_pkg::lines_after(cfg.aft_code)};
	assign l_bef = {7'h00, apsc_pkg::lines_before(cfg.bef_code)};
	assign p_aft = {4'h0, cfg.h_aft, 1'b0};
	assign p_bef = {4'h0, cfg.h_bef, 1'b0};
	assign line_ok = ({1'b0, line_cnt_r} >= l_aft) && ({1'b0, line_cnt_r} + l_bef < {1'b0, frame_len_r});
	assign pix_ok = ({1'b0, pix_cnt_r} >= p_aft) && ({1'b0, pix_cnt_r} + p_bef < {1'b0, line_len_r});
	assign win = line_ok && pix_ok && video.valid && !video.hs;
	assign level = {cfg.thr, 2'b00};
	assign hit[0] = !cfg.ch_off[apsc_pkg::OPT_BLUE] && ({2'b00, absdiff(video.pix.b, prev_r.b)} > level);
	assign hit[1] = !cfg.ch_off[apsc_pkg::OPT_GREEN] && ({2'b00, absdiff(video.pix.g, prev_r.g)} > level);
	assign hit[2] = !cfg.ch_off[apsc_pkg::OPT_RED] && ({2'b00, absdiff(video.pix.r, prev_r.r)} > level);
	assign nhit = {1'b0, hit[0]} + {1'b0, hit[1]} + {1'b0, hit[2]};
	assign acc = acc_r;

	// Pixel and line position, previous line and frame lengths
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pix_cnt_r <= 12'h000;
			line_len_r <= 12'h000;
			line_cnt_r <= 12'h000;
			frame_len_r <= 12'h000;
		end
		else
		begin
			if (video.hs)
			begin
				pix_cnt_r <= 12'h000;
				line_len_r <= pix_cnt_r;
			end
			else if (video.valid)
				pix_cnt_r <= pix_cnt_r + 12'h001;
			if (video.vs)
			begin
				line_cnt_r <= 12'h000;
				frame_len_r <= line_cnt_r;
			end
			else if (video.hs)
				line_cnt_r <= line_cnt_r + 12'h001;
		end
	end

	// Neighbour pixel and transition sum
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			prev_r <= '0;
			prev_ok_r <= 1'b0;
			acc_r <= '0;
		end
		else
		begin
			if (video.valid)
				prev_r <= video.pix;
			if (video.valid || video.hs)
				prev_ok_r <= win;
			if (clear)
				acc_r <= '0;
			else if (win && prev_ok_r)
				acc_r <= acc_r + ACC_W'(nhit);
		end
	end

	thr_scale_a: assert property (@(posedge clk) disable iff (reset)
		(cfg.thr == 8'h00) || (level == 10'(cfg.thr) * 10'd4))
		else $error("transition level is not four times the threshold");
	chan_off_a: assert property (@(posedge clk) disable iff (reset)
		cfg.ch_off[apsc_pkg::OPT_RED] |-> !hit[2])
		else $error("disabled red channel counted");
	pix_mask_a: assert property (@(posedge clk) disable iff (reset)
		win |-> (pix_cnt_r >= 12'(cfg.h_aft) * 12'd2))
		else $error("pixel counted inside after-sync mask");
	line_mask_a: assert property (@(posedge clk) disable iff (reset)
		win |-> (line_cnt_r >= 12'd5) && (line_cnt_r < frame_len_r))
		else $error("line counted inside vertical mask");
endmodule // apsc_measure
`default_nettype wire

// *** core/apsc_top.sv ***
// Automatic sampling phase search: registers, command handling and search sequencer
// Function
// - Bits 2:0 pick lines masked before vsync
// - Bits 6:4 pick lines masked after vsync
// - Each horizontal mask N hides 2N pixels
// - Option bits 0..2 drop blue, green, red
// - Option bit 3 seeks worst instead of best
// - Option bit 4: 28 or 64 vsyncs per step
// - Option bit 5: phase applies now or vsync
// - Option bit 6 holds search logic in reset
// - Used threshold is register value times four
// - Reset values 0x01, 0x01, 0x01, 0x20 readable
// - Command write runs code 011 or 100
// - Status bit 7 shows search in progress
`timescale 1ns/1ps
`default_nettype none
module apsc_top #(
	parameter int PHASE_BITS = 6,
	parameter int ACC_W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [apsc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Digitised video
	input wire apsc_pkg::apsc_video_s video,
	// Results
	output logic [PHASE_BITS-1:0] sample_phase,
	output logic window_load,
	output logic irq
);
	localparam logic [PHASE_BITS-1:0] PH_LAST = '1;
	localparam int IRQ_W_L = apsc_pkg::IRQ_W;

	logic ack_r;
	logic [31:0] rdata_r;
	logic [7:0] vmask_r, haft_r, hbef_r, opt_r, thr_r;
	logic [IRQ_W_L-1:0] sts_r, msk_r;
	apsc_pkg::apsc_state_e state_r;
	logic [PHASE_BITS-1:0] idx_r, best_ph_r, pend_r, sample_r;
	logic [6:0] vs_cnt_r;
	logic [ACC_W-1:0] best_r, acc;
	logic [31:0] result_r;
	logic first_r;
	logic [7:0] idx;
	logic wr_go, wr_lo, srst, busy, cmd_wr, step_end, better, upd;
	logic ev_done, ev_win;
	logic [6:0] steps;
	apsc_pkg::apsc_mcfg_s mcfg;

	if (PHASE_BITS < 1 || PHASE_BITS > 8)
		$error("apsc_top: PHASE_BITS must be 1..8");
	if (ACC_W < 8 || ACC_W > 32)
		$error("apsc_top: ACC_W must be 8..32");

	// Bus handshake: one wait state, then the access completes
	assign idx = address[apsc_pkg::ADDR_W-1:2];
	assign waitrequest = (read || write) && !ack_r;
	assign wr_go = write && ack_r;
	assign wr_lo = wr_go && byteenable[0];
	assign readdata = rdata_r;
	assign srst = reset || opt_r[apsc_pkg::OPT_SRST];
	assign busy = (state_r != apsc_pkg::ST_IDLE);
	assign cmd_wr = wr_lo && (idx == apsc_pkg::IDX_CMD);
	assign steps = opt_r[apsc_pkg::OPT_SLOW] ? apsc_pkg::STEP_SLOW : apsc_pkg::STEP_FAST;
	assign step_end = (state_r == apsc_pkg::ST_STEP) && video.vs && (vs_cnt_r + 7'd1 == steps);
	assign better = opt_r[apsc_pkg::OPT_WORST] ? (acc < best_r) : (acc > best_r);
	assign upd = step_end && (first_r || better);
	assign ev_done = (state_r == apsc_pkg::ST_FINAL);
	assign ev_win = (state_r == apsc_pkg::ST_WIN);
	assign window_load = ev_win;
	assign sample_phase = sample_r;
	assign irq = |(sts_r & msk_r);

	assign mcfg.bef_code = vmask_r[apsc_pkg::VM_BEF_LSB +: 3];
	assign mcfg.aft_code = vmask_r[apsc_pkg::VM_AFT_LSB +: 3];
	assign mcfg.h_aft = haft_r;
	assign mcfg.h_bef = hbef_r;
	assign mcfg.ch_off = opt_r[apsc_pkg::OPT_RED:apsc_pkg::OPT_BLUE];
	assign mcfg.thr = thr_r;

	apsc_measure #(
		.ACC_W(ACC_W)
	) u_measure (
		.clk(clk),
		.reset(srst),
		.cfg(mcfg),
		.video(video),
		.clear((state_r == apsc_pkg::ST_ARM && video.vs) || step_end),
		.acc(acc)
	);

	// Bus acknowledge and registered read data
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= (read || write) && !ack_r;
			if (read && !ack_r)
			begin
				case (idx)
					apsc_pkg::IDX_STATUS: rdata_r <= {24'h00_0000, busy, 7'h00};
					apsc_pkg::IDX_VMASK: rdata_r <= {24'h00_0000, vmask_r};
					apsc_pkg::IDX_HAFT: rdata_r <= {24'h00_0000, haft_r};
					apsc_pkg::IDX_HBEF: rdata_r <= {24'h00_0000, hbef_r};
					apsc_pkg::IDX_OPT: rdata_r <= {24'h00_0000, opt_r};
					apsc_pkg::IDX_THR: rdata_r <= {24'h00_0000, thr_r};
					apsc_pkg::IDX_RES3: rdata_r <= {24'h00_0000, result_r[31:24]};
					apsc_pkg::IDX_RES2: rdata_r <= {24'h00_0000, result_r[23:16]};
					apsc_pkg::IDX_RES1: rdata_r <= {24'h00_0000, result_r[15:8]};
					apsc_pkg::IDX_RES0: rdata_r <= {24'h00_0000, result_r[7:0]};
					apsc_pkg::IDX_IRQ_STS: rdata_r <= {30'h0000_0000, sts_r};
					apsc_pkg::IDX_IRQ_MSK: rdata_r <= {30'h0000_0000, msk_r};
					default: rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			vmask_r <= apsc_pkg::RST_VMASK;
			haft_r <= apsc_pkg::RST_HMASK;
			hbef_r <= apsc_pkg::RST_HMASK;
			opt_r <= apsc_pkg::RST_OPT;
			thr_r <= apsc_pkg::RST_THR;
			msk_r <= '0;
		end
		else if (wr_lo)
		begin
			case (idx)
				apsc_pkg::IDX_VMASK: vmask_r <= {1'b0, writedata[6:4], 1'b0, writedata[2:0]};
				apsc_pkg::IDX_HAFT: haft_r <= writedata[7:0];
				apsc_pkg::IDX_HBEF: hbef_r <= writedata[7:0];
				apsc_pkg::IDX_OPT: opt_r <= {1'b0, writedata[6:0]};
				apsc_pkg::IDX_THR: thr_r <= writedata[7:0];
				apsc_pkg::IDX_IRQ_MSK: msk_r <= writedata[IRQ_W_L-1:0];
				default: ;
			endcase
		end
	end

	// Sticky event flags, write one to clear, a new event wins
	always_ff @(posedge clk)
	begin
		if (reset)
			sts_r <= '0;
		else
		begin
			for (int i = 0; i < IRQ_W_L; i++)
			begin
				if ((i == apsc_pkg::IRQ_DONE && ev_done) || (i == apsc_pkg::IRQ_WIN && ev_win))
					sts_r[i] <= 1'b1;
				else if (wr_lo && idx == apsc_pkg::IDX_IRQ_STS && writedata[i])
					sts_r[i] <= 1'b0;
			end
		end
	end

	// Search sequencer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_r <= apsc_pkg::ST_IDLE;
			idx_r <= '0;
			vs_cnt_r <= 7'd0;
			first_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				apsc_pkg::ST_IDLE:
				begin
					if (cmd_wr && writedata[2:0] == apsc_pkg::CMD_PHASE)
					begin
						state_r <= apsc_pkg::ST_ARM;
						idx_r <= '0;
						first_r <= 1'b1;
					end
					else if (cmd_wr && writedata[2:0] == apsc_pkg::CMD_WINDOW)
						state_r <= apsc_pkg::ST_WIN;
				end
				apsc_pkg::ST_ARM:
				begin
					if (video.vs)
					begin
						state_r <= apsc_pkg::ST_STEP;
						vs_cnt_r <= 7'd0;
					end
				end
				apsc_pkg::ST_STEP:
				begin
					if (step_end)
					begin
						vs_cnt_r <= 7'd0;
						first_r <= 1'b0;
						if (idx_r == PH_LAST)
							state_r <= apsc_pkg::ST_FINAL;
						else
							idx_r <= idx_r + 1'b1;
					end
					else if (video.vs)
						vs_cnt_r <= vs_cnt_r + 7'd1;
				end
				apsc_pkg::ST_FINAL: state_r <= apsc_pkg::ST_IDLE;
				apsc_pkg::ST_WIN: state_r <= apsc_pkg::ST_IDLE;
				default: state_r <= apsc_pkg::ST_IDLE;
			endcase
		end
	end

	// Best or worst score so far and the published result
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			best_r <= '0;
			best_ph_r <= '0;
			result_r <= 32'h0000_0000;
		end
		else
		begin
			if (upd)
			begin
				best_r <= acc;
				best_ph_r <= idx_r;
			end
			if (ev_done)
				result_r <= {8'(best_ph_r), 24'(best_r)};
		end
	end

	// Phase requested by the sequencer, then applied now or at vsync
	always_ff @(posedge clk)
	begin
		if (srst)
			pend_r <= '0;
		else if (state_r == apsc_pkg::ST_IDLE && cmd_wr && writedata[2:0] == apsc_pkg::CMD_PHASE)
			pend_r <= '0;
		else if (step_end && idx_r != PH_LAST)
			pend_r <= idx_r + 1'b1;
		else if (ev_done)
			pend_r <= best_ph_r;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			sample_r <= '0;
		else if (!opt_r[apsc_pkg::OPT_VSUPD] || video.vs)
			sample_r <= pend_r;
	end

	reset_vals_a: assert property (@(posedge clk)
		reset |=> vmask_r == 8'h01 && haft_r == 8'h01 && hbef_r == 8'h01 && opt_r == 8'h20)
		else $error("register reset value wrong");
	cmd_start_a: assert property (@(posedge clk) disable iff (srst)
		(!busy && cmd_wr && writedata[2:0] == 3'b011) |=> busy ##1 busy)
		else $error("phase command did not start search");
	win_cmd_a: assert property (@(posedge clk) disable iff (srst)
		(!busy && cmd_wr && writedata[2:0] == 3'b100) |=> window_load ##1 !window_load && !busy)
		else $error("window command strobe wrong");
	bad_cmd_a: assert property (@(posedge clk) disable iff (srst)
		(!busy && cmd_wr && writedata[2:0] != 3'b011 && writedata[2:0] != 3'b100) |=> !busy)
		else $error("reserved command started work");
	soft_hold_a: assert property (@(posedge clk) disable iff (reset)
		opt_r[6] |=> state_r == apsc_pkg::ST_IDLE && sample_r == '0)
		else $error("soft reset did not hold search");
	step_len_a: assert property (@(posedge clk) disable iff (srst)
		step_end |-> vs_cnt_r == (opt_r[4] ? 7'd63 : 7'd27))
		else $error("step length wrong");
	phase_now_a: assert property (@(posedge clk) disable iff (srst)
		!opt_r[5] |=> sample_r == $past(pend_r))
		else $error("immediate phase not applied");
	phase_vs_a: assert property (@(posedge clk) disable iff (srst)
		opt_r[5] && !video.vs |=> sample_r == $past(sample_r))
		else $error("phase changed outside vsync");
	search_dir_a: assert property (@(posedge clk) disable iff (srst)
		upd && !first_r |-> (opt_r[3] ? acc < best_r : acc > best_r))
		else $error("search kept the wrong phase");
	busy_read_a: assert property (@(posedge clk) disable iff (srst)
		read && !ack_r && idx == 8'h51 |=> readdata[7] == $past(busy))
		else $error("busy status misreported");
	irq_sticky_a: assert property (@(posedge clk) disable iff (reset)
		sts_r[0] && !(wr_lo && idx == 8'h5C && writedata[0]) |=> sts_r[0])
		else $error("event flag lost");
endmodule // apsc_top
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench of the phase search control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed
	{
		logic [7:0] idx;
		logic wr;
		logic [7:0] wd;
		logic [7:0] ex;
	} apsc_row_s;

	logic clk;
	logic reset = 1'b1;
	logic [apsc_pkg::ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [3:0] byteenable = '0;
	logic [31:0] readdata;
	logic waitrequest;
	apsc_pkg::apsc_video_s video = '0;
	logic [5:0] sample_phase;
	logic window_load;
	logic irq;
	logic [5:0] vcnt = '0;
	logic rich = 1'b0;
	logic [31:0] rd;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int vs_total = 0;
	int wl_cnt = 0;
	int base;

	// Reset reads first, then write and read back
	apsc_row_s rows [16] = '{
		'{apsc_pkg::IDX_VMASK, 1'b0, 8'h00, 8'h01}, '{apsc_pkg::IDX_HAFT, 1'b0, 8'h00, 8'h01},
		'{apsc_pkg::IDX_HBEF, 1'b0, 8'h00, 8'h01}, '{apsc_pkg::IDX_OPT, 1'b0, 8'h00, 8'h20},
		'{apsc_pkg::IDX_THR, 1'b0, 8'h00, 8'h0A}, '{apsc_pkg::IDX_STATUS, 1'b0, 8'h00, 8'h00},
		'{apsc_pkg::IDX_IRQ_MSK, 1'b0, 8'h00, 8'h00}, '{apsc_pkg::IDX_IRQ_STS, 1'b0, 8'h00, 8'h00},
		'{apsc_pkg::IDX_RES3, 1'b0, 8'h00, 8'h00}, '{apsc_pkg::IDX_VMASK, 1'b1, 8'hFF, 8'h77},
		'{apsc_pkg::IDX_HAFT, 1'b1, 8'hA5, 8'hA5}, '{apsc_pkg::IDX_HBEF, 1'b1, 8'h5A, 8'h5A},
		'{apsc_pkg::IDX_THR, 1'b1, 8'hFF, 8'hFF}, '{apsc_pkg::IDX_OPT, 1'b1, 8'h1F, 8'h1F},
		'{apsc_pkg::IDX_RES3, 1'b1, 8'hFF, 8'h00}, '{8'h70, 1'b1, 8'hFF, 8'h00}
	};

	apsc_top #(.PHASE_BITS(6), .ACC_W(32)) i_dut (
		.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .video(video), .sample_phase(sample_phase),
		.window_load(window_load), .irq(irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Short frame of one line, or long frame of eight lines with toggling pixels
	always @(posedge clk)
	begin
		vcnt <= (vcnt >= (rich ? 6'h2F : 6'h13)) ? 6'h00 : vcnt + 6'h01;
		video.hs <= rich ? (vcnt % 6'h06 == 6'h00) : (vcnt == 6'h09);
		video.vs <= (vcnt == (rich ? 6'h2F : 6'h13));
		video.valid <= rich && (vcnt % 6'h06 != 6'h00);
		video.pix <= vcnt[0] ? 24'hFF_FFFF : 24'h00_0000;
		if (video.vs === 1'b1)
			vs_total <= vs_total + 1;
		if (window_load === 1'b1)
			wl_cnt <= wl_cnt + 1;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			failures++;
			wrap_up();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		address <= {idx, 2'b00};
		write <= wr;
		read <= !wr;
		writedata <= {24'h000000, d};
		byteenable <= 4'hF;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(name, rd, {24'h000000, exp});
	endtask

	task automatic wait_vs(input int n);
		repeat (n) @(posedge clk iff video.vs === 1'b1);
	endtask

	task automatic wrap_up();
		$display("compared %0d, mismatched %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				bus(1'b1, rows[i].idx, rows[i].wd);
			rd_chk("register", rows[i].idx, rows[i].ex);
		end
		bus(1'b1, apsc_pkg::IDX_VMASK, 8'h01);
		bus(1'b1, apsc_pkg::IDX_HAFT, 8'h01);
		bus(1'b1, apsc_pkg::IDX_HBEF, 8'h01);
		bus(1'b1, apsc_pkg::IDX_THR, 8'h0A);
		bus(1'b1, apsc_pkg::IDX_OPT, 8'h20);
		$display("test registers done");

		// Window command, masked then unmasked interrupt, clear
		bus(1'b1, apsc_pkg::IDX_CMD, 8'h04);
		repeat (2) @(negedge clk);
		check("window_load count", wl_cnt, 1);
		check("irq masked", {31'h0, irq}, 32'h0);
		rd_chk("irq status", apsc_pkg::IDX_IRQ_STS, 8'h02);
		bus(1'b1, apsc_pkg::IDX_IRQ_MSK, 8'h03);
		@(negedge clk);
		check("irq unmasked", {31'h0, irq}, 32'h1);
		bus(1'b1, apsc_pkg::IDX_IRQ_STS, 8'h02);
		rd_chk("irq cleared", apsc_pkg::IDX_IRQ_STS, 8'h00);
		@(negedge clk);
		check("irq low", {31'h0, irq}, 32'h0);
		for (int c = 0; c < 8; c++)
			if (c != 3 && c != 4)
			begin
				bus(1'b1, apsc_pkg::IDX_CMD, c[7:0]);
				rd_chk("reserved busy", apsc_pkg::IDX_STATUS, 8'h00);
			end
		check("reserved window_load", wl_cnt, 1);
		$display("test commands done");

		// Full search, phase applied at vsync
		wait_vs(1);
		bus(1'b1, apsc_pkg::IDX_CMD, 8'h03);
		base = vs_total;
		rd_chk("busy", apsc_pkg::IDX_STATUS, 8'h80);
		bus(1'b1, apsc_pkg::IDX_CMD, 8'h04);
		rd_chk("busy kept", apsc_pkg::IDX_STATUS, 8'h80);
		check("command while busy", wl_cnt, 1);
		wait_vs(29);
		repeat (5) @(negedge clk);
		check("phase held", {26'h0, sample_phase}, 32'h0);
		wait_vs(1);
		repeat (5) @(negedge clk);
		check("phase on vsync", {26'h0, sample_phase}, 32'h1);
		for (int k = 0; k < 20000; k++)
		begin
			bus(1'b0, apsc_pkg::IDX_STATUS, 8'h00);
			if (rd[7] === 1'b0)
				break;
		end
		check("vsyncs per search", vs_total - base, 1 + 64 * 28);
		rd_chk("done status", apsc_pkg::IDX_IRQ_STS, 8'h01);
		rd_chk("best phase", apsc_pkg::IDX_RES3, 8'h00);
		@(negedge clk);
		check("irq done", {31'h0, irq}, 32'h1);
		bus(1'b1, apsc_pkg::IDX_IRQ_STS, 8'h01);
		$display("test search done");

		// Immediate update, red channel off, long frames, then soft reset in mid-search
		bus(1'b1, apsc_pkg::IDX_OPT, 8'h04);
		rich <= 1'b1;
		wait_vs(1);
		bus(1'b1, apsc_pkg::IDX_CMD, 8'h03);
		wait_vs(29);
		repeat (5) @(negedge clk);
		check("phase immediate", {26'h0, sample_phase}, 32'h1);
		bus(1'b1, apsc_pkg::IDX_OPT, 8'h40);
		rd_chk("soft reset idle", apsc_pkg::IDX_STATUS, 8'h00);
		check("soft reset phase", {26'h0, sample_phase}, 32'h0);
		bus(1'b1, apsc_pkg::IDX_OPT, 8'h20);
		bus(1'b1, apsc_pkg::IDX_CMD, 8'h04);
		repeat (2) @(negedge clk);
		check("after soft reset", wl_cnt, 2);
		$display("test soft reset done");

		// Reset in mid-run restores defaults
		bus(1'b1, apsc_pkg::IDX_THR, 8'h33);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd_chk("threshold after reset", apsc_pkg::IDX_THR, 8'h0A);
		rd_chk("mask after reset", apsc_pkg::IDX_IRQ_MSK, 8'h00);
		$display("test reset done");
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
